// ==== hw/ste_elem.sv ====
// one sensor element: condition detection, averaging and event request
`timescale 1ns/10ps
module ste_elem
  import ste_pkg::*;
#(
  parameter int TICK_CYC = STE_TICK_CYC
)
(
  input wire logic i_mclk, // system clock
  input wire logic i_nrst, // async reset, active low
  input wire logic i_tick, // 50 ms enable pulse
  input wire logic i_sample, // new value strobe
  input wire logic [15:0] i_value, // sampled value
  input wire ste_cfg_s i_cfg, // element settings
  output ste_req_s o_req, // event and transmit requests
  output logic o_mon // continuous transmission active
);
  // ---------------------------------------------------------------
  // condition decode
  // ---------------------------------------------------------------
  logic in_rng; // value within bounds, bounds inclusive
  logic in_prev_q; // range state at the priming sample or the last event
  logic [15:0] ref_q; // reference value for step mode
  logic [15:0] diff; // absolute change from reference
  logic [3:0] base; // type with monitoring folded away
  logic mon_type; // type is monitoring flavoured
  logic cond; // triggering condition now
  logic mon_q; // monitoring latched
  logic [15:0] cnt_q; // elapsed ticks
  ste_state_e st_q; // averaging state
  logic fire; // event fires this cycle
  assign in_rng = (i_value <= i_cfg.upper) && (i_value >= i_cfg.lower);
  assign diff = (i_value >= ref_q) ? i_value - ref_q : ref_q - i_value;
  assign mon_type = (i_cfg.ev_type >= STE_EV_MON_BASE) && (i_cfg.ev_type < STE_EV_STEP);
  assign base = mon_type ? i_cfg.ev_type - STE_EV_MON_BASE : i_cfg.ev_type;
  // condition is level-held: range state, or for step types the value, differs from that at the last event
  always_comb
  begin
    case (base)
      STE_EV_IN: cond = in_rng && !in_prev_q;
      STE_EV_OUT: cond = !in_rng && in_prev_q;
      STE_EV_CROSS: cond = in_rng != in_prev_q;
      STE_EV_STEP, STE_EV_STEP_MON: cond = (diff >= i_cfg.upper) && (i_cfg.upper != 16'h0000);
      default: cond = 1'b0; // monitoring and codes above 8 raise nothing
    endcase
  end
  assign fire = i_cfg.enable && cond && (st_q == STE_WAIT) && (cnt_q >= i_cfg.avg);
  // ---------------------------------------------------------------
  // averaging state machine
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      st_q <= STE_IDLE;
      cnt_q <= 16'h0000;
    end
    else
    begin
      case (st_q)
        STE_IDLE:
        begin
          cnt_q <= 16'h0000;
          if (i_cfg.enable && cond)
            st_q <= STE_WAIT;
        end
        STE_WAIT:
        begin
          if (!cond || !i_cfg.enable)
          begin
            st_q <= STE_IDLE; // lapse restarts the timer
            cnt_q <= 16'h0000;
          end
          else if (fire)
            st_q <= STE_DONE;
          else if (i_tick)
            cnt_q <= cnt_q + 16'h0001;
        end
        STE_DONE:
          st_q <= STE_IDLE; // reference updated, condition re-evaluated
        default:
          st_q <= STE_IDLE;
      endcase
    end
  end
  // ---------------------------------------------------------------
  // reference tracking: range state and step reference move on event
  // ---------------------------------------------------------------
  // the reference only moves when an event fires so slow drift still
  // accumulates into a step; first sample primes it
  logic primed_q; // reference loaded once
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      in_prev_q <= 1'b0;
      ref_q <= 16'h0000;
      primed_q <= 1'b0;
    end
    else if (i_sample && !primed_q)
    begin
      in_prev_q <= in_rng;
      ref_q <= i_value;
      primed_q <= 1'b1;
    end
    else if (fire)
    begin
      in_prev_q <= in_rng;
      ref_q <= i_value;
    end
  end
  // ---------------------------------------------------------------
  // monitoring latch and requests
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      mon_q <= 1'b0;
      o_req <= '0;
    end
    else
    begin
      if (!i_cfg.enable)
        mon_q <= 1'b0; // off: nothing transmitted
      else if (i_cfg.ev_type == STE_EV_MON)
        mon_q <= 1'b1;
      else if (fire && (mon_type || i_cfg.ev_type == STE_EV_STEP_MON))
        mon_q <= 1'b1;
      else if (!mon_type && i_cfg.ev_type != STE_EV_STEP_MON)
        mon_q <= 1'b0;
      o_req.event_p <= fire;
      o_req.send_now <= i_cfg.enable && i_cfg.prio_high && (fire || (mon_q && i_sample));
      o_req.mark_next <= i_cfg.enable && !i_cfg.prio_high && (fire || (mon_q && i_sample));
    end
  end
  assign o_mon = mon_q;
endmodule

// ==== hw/ste_pkg.sv ====
// package: constants, settings layout and types of the sensor threshold event generator
package ste_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] STE_ADDR_SEL = 8'h00; // element group number
  localparam logic [7:0] STE_ADDR_SET0 = 8'h10; // setting index 0 .. 5 at 0x10 + 4*idx
  localparam logic [7:0] STE_ADDR_VAL = 8'h30; // sensor value of selected element
  localparam logic [7:0] STE_ADDR_STAT = 8'h34; // sticky event status, w1c
  localparam logic [7:0] STE_ADDR_MASK = 8'h38; // interrupt mask
  localparam logic [7:0] STE_ADDR_MON = 8'h3c; // monitoring state, read only
  localparam int STE_NUM_SET = 6; // settings per element
  localparam int STE_SET_SHIFT = 2; // word index shift
  localparam logic [31:0] STE_BAD_DATA = 32'hdeadbeef; // unmapped read answer
  // ---------------------------------------------------------------
  // setting codes
  // ---------------------------------------------------------------
  localparam logic [3:0] STE_EV_IN = 4'h0; // enters range
  localparam logic [3:0] STE_EV_OUT = 4'h1; // leaves range
  localparam logic [3:0] STE_EV_CROSS = 4'h2; // any crossing
  localparam logic [3:0] STE_EV_MON = 4'h3; // monitoring only
  localparam logic [3:0] STE_EV_MON_BASE = 4'h4; // types 4..6 = 0..2 + monitoring
  localparam logic [3:0] STE_EV_STEP = 4'h7; // change by step
  localparam logic [3:0] STE_EV_STEP_MON = 4'h8; // step + monitoring
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int STE_CLK_MHZ = 200; // system clock rate
  localparam int STE_TICK_MS = 50; // averaging time base
  localparam int STE_TICK_CYC = STE_TICK_MS * 1000 * STE_CLK_MHZ; // 10,000,000 cycles
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic enable; // index 0
    logic prio_high; // index 1
    logic [15:0] upper; // index 2, also change step
    logic [15:0] lower; // index 3
    logic [3:0] ev_type; // index 4
    logic [15:0] avg; // index 5, in 50 ms ticks
  } ste_cfg_s;
  typedef struct packed {
    logic event_p; // one-cycle event pulse
    logic send_now; // high priority transmit request
    logic mark_next; // queue for next regular packet
  } ste_req_s;
  typedef enum logic [2:0] {
    STE_IDLE = 3'b001, // condition absent
    STE_WAIT = 3'b010, // condition held, timing
    STE_DONE = 3'b100 // event fired, back to idle on the next cycle
  } ste_state_e;
endpackage

// ==== hw/ste_top.sv ====
// top: register slave, settings store, time base and element array
//
// Chosen here: the register offsets and the Avalon-MM register port.
`timescale 1ns/10ps
// What this block does
// - six settings per element, group then index
// - index zero enables or disables transmission
// - priority: low queues, high sends immediately
// - index two upper, three lower bound
// - type zero: event on entering range
// - type one: event on leaving range
// - type two: event on every crossing
// - type three: continuous transmission, no events
// - types four to six add monitoring after event
// - type seven: event on change by step
// - type eight: step event then monitoring
// - event after condition held avg times 50ms
module ste_top
  import ste_pkg::*;
#(
  parameter int N_ELEM = 4, // sensor elements
  parameter int TICK_CYC = STE_TICK_CYC // cycles per 50 ms tick
)
(
  input wire logic i_mclk, // system clock 200 MHz
  input wire logic i_nrst, // async reset, active low
  input wire logic [7:0] i_avs_address, // byte address
  input wire logic i_avs_read, // read request
  input wire logic i_avs_write, // write request
  input wire logic [31:0] i_avs_writedata, // write data
  input wire logic [3:0] i_avs_byteenable, // byte lanes
  output logic [31:0] o_avs_readdata, // read data
  output logic o_avs_waitrequest, // stall
  input wire logic [N_ELEM-1:0] i_sample, // per-element new value strobe
  input wire logic [N_ELEM*16-1:0] i_value, // per-element values
  output logic [N_ELEM-1:0] o_event, // event pulses
  output logic [N_ELEM-1:0] o_send_now, // immediate transmit requests
  output logic [N_ELEM-1:0] o_mark_next, // next-packet marks
  output logic o_irq // level interrupt
);
  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  localparam int GW = (N_ELEM > 1) ? $clog2(N_ELEM) : 1; // group index width
  ste_cfg_s cfg_q [N_ELEM]; // settings store
  logic [GW-1:0] sel_q; // selected group
  logic [N_ELEM-1:0] stat_q; // sticky events
  logic [N_ELEM-1:0] mask_q; // interrupt enables
  logic [N_ELEM-1:0] ev; // event pulses from elements
  logic [N_ELEM-1:0] mon; // monitoring state
  logic [N_ELEM-1:0] snow; // send now
  logic [N_ELEM-1:0] mnext; // mark next
  logic ack_q; // one wait-state answer
  logic wait_q; // registered stall, high out of reset
  logic [7:0] set_word; // word offset into the settings window
  logic [31:0] rdata_q; // registered read data
  logic [31:0] tick_cnt_q; // time base counter
  logic tick_q; // 50 ms enable pulse
  logic req; // bus request pending
  logic wr_go; // write accepted this cycle
  logic [2:0] set_idx; // decoded setting index
  logic set_hit; // address in settings window
  logic [31:0] rd_mux; // read data selection
  logic [31:0] be_mask; // byte-enable mask
  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  // merge write data into old value under byte enables
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction
  // read one setting of a config as a word
  function automatic logic [31:0] get_set(input ste_cfg_s c, input logic [2:0] i);
    case (i)
      3'h0: get_set = {31'h0, c.enable};
      3'h1: get_set = {31'h0, c.prio_high};
      3'h2: get_set = {16'h0, c.upper};
      3'h3: get_set = {16'h0, c.lower};
      3'h4: get_set = {28'h0, c.ev_type};
      default: get_set = {16'h0, c.avg};
    endcase
  endfunction
  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  assign req = (i_avs_read || i_avs_write) && !ack_q;
  assign wr_go = i_avs_write && ack_q;
  // full-width offset: a 3-bit index would wrap 0x30..0x3c back onto the settings
  assign set_word = (i_avs_address - STE_ADDR_SET0) >> STE_SET_SHIFT;
  assign set_idx = set_word[2:0];
  assign set_hit = (i_avs_address >= STE_ADDR_SET0) && (i_avs_address[1:0] == 2'h0)
                   && (set_word < 8'(STE_NUM_SET));
  assign be_mask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                    {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
  always_comb
  begin
    rd_mux = STE_BAD_DATA;
    if (set_hit)
      rd_mux = get_set(cfg_q[sel_q], set_idx);
    else
    begin
      case (i_avs_address)
        STE_ADDR_SEL: rd_mux = 32'(sel_q);
        STE_ADDR_VAL: rd_mux = {16'h0, i_value[16*sel_q +: 16]};
        STE_ADDR_STAT: rd_mux = 32'(stat_q);
        STE_ADDR_MASK: rd_mux = 32'(mask_q);
        STE_ADDR_MON: rd_mux = 32'(mon);
        default: rd_mux = STE_BAD_DATA;
      endcase
    end
  end
  // ---------------------------------------------------------------
  // bus handshake: every access answered one cycle after it starts
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ack_q <= 1'b0;
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= req;
      wait_q <= !req; // stall output straight from a flop, always the inverse of ack_q
      if (req && i_avs_read)
        rdata_q <= rd_mux;
    end
  end
  assign o_avs_waitrequest = wait_q;
  assign o_avs_readdata = rdata_q;
  // ---------------------------------------------------------------
  // settings store
  // ---------------------------------------------------------------
  // written through the selected group so the map stays fixed for any N_ELEM
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      sel_q <= '0;
      mask_q <= '0;
      for (int k = 0; k < N_ELEM; k++)
        cfg_q[k] <= '0;
    end
    else if (wr_go)
    begin
      if (i_avs_address == STE_ADDR_SEL)
        sel_q <= GW'(merge(32'(sel_q), i_avs_writedata, be_mask));
      else if (i_avs_address == STE_ADDR_MASK)
        mask_q <= N_ELEM'(merge(32'(mask_q), i_avs_writedata, be_mask));
      else if (set_hit)
      begin
        case (set_idx)
          3'h0: cfg_q[sel_q].enable <= i_avs_writedata[0];
          3'h1: cfg_q[sel_q].prio_high <= i_avs_writedata[0];
          3'h2: cfg_q[sel_q].upper <= 16'(merge(32'(cfg_q[sel_q].upper), i_avs_writedata, be_mask));
          3'h3: cfg_q[sel_q].lower <= 16'(merge(32'(cfg_q[sel_q].lower), i_avs_writedata, be_mask));
          3'h4: cfg_q[sel_q].ev_type <= i_avs_writedata[3:0];
          default: cfg_q[sel_q].avg <= 16'(merge(32'(cfg_q[sel_q].avg), i_avs_writedata, be_mask));
        endcase
      end
    end
  end
  // ---------------------------------------------------------------
  // 50 ms time base
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end
    else if (tick_cnt_q == 32'(TICK_CYC - 1))
    begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q <= 1'b1;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
      tick_q <= 1'b0;
    end
  end
  // ---------------------------------------------------------------
  // element array
  // ---------------------------------------------------------------
  for (genvar g = 0; g < N_ELEM; g++)
  begin : g_el
    ste_req_s r; // element requests
    ste_elem #(.TICK_CYC(TICK_CYC)) u_el (
      .i_mclk(i_mclk),
      .i_nrst(i_nrst),
      .i_tick(tick_q),
      .i_sample(i_sample[g]),
      .i_value(i_value[16*g +: 16]),
      .i_cfg(cfg_q[g]),
      .o_req(r),
      .o_mon(mon[g])
    );
    assign ev[g] = r.event_p;
    assign snow[g] = r.send_now;
    assign mnext[g] = r.mark_next;
  end
  // ---------------------------------------------------------------
  // outputs and interrupt: set wins over w1c clear
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      stat_q <= '0;
      o_irq <= 1'b0;
      o_event <= '0;
      o_send_now <= '0;
      o_mark_next <= '0;
    end
    else
    begin
      if (wr_go && i_avs_address == STE_ADDR_STAT)
        stat_q <= (stat_q & ~N_ELEM'(i_avs_writedata & be_mask)) | ev;
      else
        stat_q <= stat_q | ev;
      o_irq <= |(stat_q & mask_q);
      o_event <= ev;
      o_send_now <= snow;
      o_mark_next <= mnext;
    end
  end
endmodule

// ==== sim/ste_srv_model.sv ====
// far side model: packet logic taking immediate sends and queued marks
`timescale 1ns/10ps
module ste_srv_model
  import ste_pkg::*;
#(
  parameter int N_ELEM = 4 // sensor elements
)
(
  input wire logic i_mclk, // system clock
  input wire logic i_nrst, // async reset, active low
  input wire logic [N_ELEM-1:0] i_send_now, // immediate requests
  input wire logic [N_ELEM-1:0] i_mark_next, // queued marks
  input wire logic i_pkt, // regular packet leaves
  output logic [15:0] o_n_now, // immediate packets sent
  output logic [15:0] o_n_queued // elements carried by regular packets
);
  logic [N_ELEM-1:0] pend_q; // elements waiting for the next packet
  // ----
  // send accounting
  // ----
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_n_now <= '0;
      o_n_queued <= '0;
      pend_q <= '0;
    end
    else
    begin
      // high priority goes out at once
      o_n_now <= o_n_now + 16'($countones(i_send_now));
      // low priority rides on the next packet; a mark on the flush edge waits
      pend_q <= i_pkt ? i_mark_next : (pend_q | i_mark_next);
      if (i_pkt)
        o_n_queued <= o_n_queued + 16'($countones(pend_q));
    end
  end
endmodule

// ==== sim/ste_top_checker.sv ====
// checker: bus handshake and element request assertions for ste_top
`timescale 1ns/10ps
module ste_top_checker
  import ste_pkg::*;
#(
  parameter int N_ELEM = 4 // sensor elements
)
(
  input wire logic i_mclk, // system clock
  input wire logic i_nrst, // async reset, active low
  input wire logic [7:0] i_avs_address, // byte address
  input wire logic i_avs_read, // read request
  input wire logic i_avs_write, // write request
  input wire logic [31:0] i_avs_writedata, // write data
  input wire logic [3:0] i_avs_byteenable, // byte lanes
  input wire logic [31:0] o_avs_readdata, // read data
  input wire logic o_avs_waitrequest, // stall
  input wire logic [N_ELEM-1:0] i_sample, // value strobes
  input wire logic [N_ELEM*16-1:0] i_value, // values
  input wire logic [N_ELEM-1:0] o_event, // event pulses
  input wire logic [N_ELEM-1:0] o_send_now, // immediate requests
  input wire logic [N_ELEM-1:0] o_mark_next, // queued marks
  input wire logic o_irq // level interrupt
);
  // ----
  // address decode
  // ----
  wire logic req = i_avs_read | i_avs_write; // any access
  // setting words 0x10..0x24, word aligned only
  wire logic is_set = (i_avs_address >= 8'h10) && (i_avs_address <= 8'h24)
    && (i_avs_address[1:0] == 2'b00);
  wire logic mapped = is_set || (i_avs_address == STE_ADDR_SEL)
    || (i_avs_address == STE_ADDR_VAL) || (i_avs_address == STE_ADDR_STAT)
    || (i_avs_address == STE_ADDR_MASK) || (i_avs_address == STE_ADDR_MON);
  // ----
  // assertions, one clock domain
  // ----
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  AST_WAIT_ANSWER: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("waitrequest did not drop one cycle after request");
  AST_WAIT_ONE: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_WAIT_IDLE: assert property (!req |=> o_avs_waitrequest)
    else $error("waitrequest low without a request");
  AST_BAD_READ: assert property (i_avs_read && o_avs_waitrequest && !mapped
    |=> o_avs_readdata == STE_BAD_DATA)
    else $error("unmapped read did not return the filler word");
  AST_RDATA_HOLD: assert property (!i_avs_read |=> $stable(o_avs_readdata))
    else $error("read data changed without a read");
  AST_EVENT_REQ: assert property ((o_event & ~(o_send_now | o_mark_next)) == '0)
    else $error("event without a transmit request");
  AST_REQ_EXCL: assert property ((o_send_now & o_mark_next) == '0)
    else $error("send and mark both high for one element");
  AST_EVENT_PULSE: assert property (o_event != '0 |=> (o_event & $past(o_event)) == '0)
    else $error("event pulse longer than one cycle");
endmodule
bind ste_top ste_top_checker #(.N_ELEM(N_ELEM)) u_chk (.i_mclk(i_mclk), .i_nrst(i_nrst),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .i_sample(i_sample), .i_value(i_value), .o_event(o_event), .o_send_now(o_send_now),
  .o_mark_next(o_mark_next), .o_irq(o_irq));

// ==== sim/tb.sv ====
// testbench: register bus tasks and a table of per-element event scenarios
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[ERR] %0t got %0h want %0h", $time, (a), (b)); end end
module tb;
  import ste_pkg::*;
  localparam int N = 18; // one fresh element per scenario
  localparam int T = 10; // short tick keeps averaging runs brief
  logic i_mclk = 1'b0;
  logic i_nrst = 1'b0;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [N-1:0] smp = '0;
  logic [N*16-1:0] val = '0;
  logic pkt = 1'b0;
  logic [31:0] rdat;
  logic wreq;
  logic [N-1:0] ev_o;
  logic [N-1:0] now_o;
  logic [N-1:0] mark_o;
  logic irq;
  logic [15:0] n_now;
  logic [15:0] n_queued;
  logic [31:0] q;
  logic [N-1:0] exp_pend = '0; // elements expected in the regular packet
  int exp_now = 0;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  // ----
  // clock, design, far side
  // ----
  always #2.5 i_mclk = ~i_mclk;
  ste_top #(.N_ELEM(N), .TICK_CYC(T)) dut (.i_mclk(i_mclk), .i_nrst(i_nrst),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
    .i_avs_byteenable(4'hf), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
    .i_sample(smp), .i_value(val), .o_event(ev_o), .o_send_now(now_o),
    .o_mark_next(mark_o), .o_irq(irq));
  ste_srv_model #(.N_ELEM(N)) u_srv (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_send_now(now_o),
    .i_mark_next(mark_o), .i_pkt(pkt), .o_n_now(n_now), .o_n_queued(n_queued));
  // ----
  // tasks
  // ----
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // hang guard, far above the few thousand cycles needed
  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      summarize();
    end
  end
  // one access: raised after an edge, held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge i_mclk);
    adr <= a;
    wdat <= d;
    rd <= !w;
    wr <= w;
    do @(posedge i_mclk); while (wreq !== 1'b0);
    r = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // configure element g, prime on v0, move to v1 and watch the outputs
  task automatic run(input int g, input logic en, input logic [3:0] t, input logic p,
    input logic [15:0] av, up, lo, v0, v1, input int ev, input logic dip);
    logic [31:0] s[6];
    logic [31:0] m[6];
    int ne, ns, nm, lat, lo_b, hi_b;
    logic mon;
    s = '{{31'h0, en}, {31'h0, p}, {16'h0, up}, {16'h0, lo}, {28'h0, t}, {16'h0, av}};
    m = '{32'h1, 32'h1, 32'hffff, 32'hffff, 32'hf, 32'hffff};
    bus(1'b1, STE_ADDR_SEL, 32'(g), q);
    // enable goes last so the element never runs on half-written settings
    for (int i = 1; i <= 6; i++) bus(1'b1, STE_ADDR_SET0 + 8'(4 * (i % 6)), s[i % 6], q);
    for (int i = 0; i < 6; i++)
    begin
      bus(1'b0, STE_ADDR_SET0 + 8'(4 * i), 32'h0, q);
      `CHK(q & m[i], s[i])
    end
    @(posedge i_mclk);
    val[16*g+:16] <= v0;
    smp[g] <= 1'b1;
    @(posedge i_mclk);
    smp[g] <= 1'b0;
    repeat (10) @(posedge i_mclk);
    if (dip)
    begin
      val[16*g+:16] <= v1;
      repeat (15) @(posedge i_mclk);
      val[16*g+:16] <= v0;
      repeat (5) @(posedge i_mclk);
    end
    val[16*g+:16] <= v1;
    ne = 0; ns = 0; nm = 0; lat = -1;
    for (int c = 0; c < 80; c++)
    begin
      @(negedge i_mclk);
      if (ev_o[g] === 1'b1 && lat < 0) lat = c;
      ne += int'(ev_o[g] === 1'b1);
      ns += int'(now_o[g] === 1'b1);
      nm += int'(mark_o[g] === 1'b1);
    end
    `CHK(ne, ev)
    `CHK(ns, p ? ev : 0)
    `CHK(nm, p ? 0 : ev)
    lo_b = (av == 0) ? 0 : (int'(av) - 1) * T;
    hi_b = int'(av) * T + T + 8;
    if (ev > 0) `CHK(lat >= lo_b && lat <= hi_b, 1'b1)
    mon = (t == STE_EV_MON) || (ev > 0 && (t inside {4'h4, 4'h5, 4'h6, 4'h8}));
    bus(1'b0, STE_ADDR_MON, 32'h0, q);
    `CHK(q[g], mon)
    bus(1'b0, STE_ADDR_STAT, 32'h0, q);
    `CHK(q[g], ev > 0)
    @(posedge i_mclk);
    smp[g] <= 1'b1;
    @(posedge i_mclk);
    smp[g] <= 1'b0;
    ns = 0; nm = 0;
    repeat (10)
    begin
      @(negedge i_mclk);
      ns += int'(now_o[g] === 1'b1);
      nm += int'(mark_o[g] === 1'b1);
    end
    `CHK(ns + nm, mon ? 1 : 0)
    exp_now += p ? (ev + (mon ? 1 : 0)) : 0;
    if (!p && (ev > 0 || mon)) exp_pend[g] = 1'b1;
    $display("test element %0d done", g);
  endtask
  // ----
  // main sequence
  // ----
  initial
  begin
    repeat (16) @(posedge i_mclk);
    i_nrst <= 1'b1;
    @(posedge i_mclk);
    run(0, 1, 4'h0, 0, 0, 200, 100, 50, 200, 1, 0);
    run(1, 1, 4'h0, 0, 0, 200, 100, 150, 300, 0, 0);
    run(2, 1, 4'h1, 1, 0, 200, 100, 150, 201, 1, 0);
    run(3, 1, 4'h1, 1, 0, 200, 100, 300, 150, 0, 0);
    run(4, 1, 4'h2, 0, 0, 200, 100, 50, 100, 1, 0);
    run(5, 1, 4'h2, 1, 0, 200, 100, 150, 99, 1, 0);
    run(6, 1, 4'h3, 0, 0, 200, 100, 50, 150, 0, 0);
    run(7, 1, 4'h4, 1, 0, 200, 100, 50, 150, 1, 0);
    run(8, 1, 4'h5, 0, 0, 200, 100, 150, 250, 1, 0);
    run(9, 1, 4'h6, 0, 0, 200, 100, 250, 150, 1, 0);
    run(10, 1, 4'h7, 1, 0, 10, 0, 1000, 1010, 1, 0);
    run(11, 1, 4'h7, 0, 0, 10, 0, 1000, 1009, 0, 0);
    run(12, 1, 4'h8, 0, 0, 10, 0, 1000, 990, 1, 0);
    run(13, 1, 4'h9, 0, 0, 200, 100, 50, 150, 0, 0);
    run(14, 1, 4'h0, 0, 3, 200, 100, 50, 150, 1, 1);
    run(16, 0, 4'h0, 0, 0, 200, 100, 50, 150, 0, 0);
    run(15, 1, 4'h0, 1, 2, 200, 100, 50, 150, 1, 0);
    // status set but masked: line stays low, then mask, then clear
    `CHK(irq, 1'b0)
    bus(1'b1, STE_ADDR_MASK, 32'h0000_8000, q);
    repeat (3) @(posedge i_mclk);
    `CHK(irq, 1'b1)
    bus(1'b1, STE_ADDR_STAT, 32'h0000_8000, q);
    repeat (3) @(posedge i_mclk);
    `CHK(irq, 1'b0)
    bus(1'b0, STE_ADDR_STAT, 32'h0, q);
    `CHK(q[15], 1'b0)
    bus(1'b0, 8'h28, 32'h0, q);
    `CHK(q, STE_BAD_DATA)
    bus(1'b0, STE_ADDR_VAL, 32'h0, q);
    `CHK(q[15:0], 16'd150)
    @(posedge i_mclk);
    pkt <= 1'b1;
    @(posedge i_mclk);
    pkt <= 1'b0;
    repeat (2) @(posedge i_mclk);
    `CHK(n_now, 16'(exp_now))
    `CHK(n_queued, 16'($countones(exp_pend)))
    summarize();
  end
endmodule
